/* include/fpu_pkg.sv */
// constants, types and operation codes for the fp abs/add/compare slice
// assumes the issuing core decodes instructions and evaluates its own condition codes
package fpu_pkg;
   localparam int WORD_W = 32;
   localparam int REG_AW = 5;
   localparam int SIGN_BIT = 31;
   localparam int EXP_HI = 30;
   localparam int EXP_LO = 23;
   localparam int QUIET_BIT = 22;
   localparam int MAN_W = 23;
   localparam logic [7:0] EXP_MAX = 8'hff;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;
   localparam logic [31:0] QNAN_DEFAULT = 32'h7fc00000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   // flag nibble order n,z,c,v
   localparam logic [3:0] FLAGS_EQ = 4'h6;
   localparam logic [3:0] FLAGS_LT = 4'h8;
   localparam logic [3:0] FLAGS_GT = 4'h2;
   localparam logic [3:0] FLAGS_UN = 4'h3;

   typedef enum logic [1:0] {
      FPU_OP_ABS,
      FPU_OP_ADD,
      FPU_OP_CMP
   } fpu_op_t;

   typedef struct packed {
      fpu_op_t op;
      logic cond_pass;
      logic cmp_zero;
      logic cmp_any_nan;
      logic [REG_AW-1:0] dest;
      logic [REG_AW-1:0] src_a;
      logic [REG_AW-1:0] src_b;
   } fpu_cmd_t;

   typedef struct packed {
      logic [3:0] flags;
      logic invalid;
   } fpu_status_t;
endpackage

/* hdl/fpu_slice.sv */
// fp abs / add / compare execution slice with its own single-precision register file
// assumes commands arrive as one-cycle strobes from core logic on MCLK; no back-pressure
`timescale 1ns/100ps
module fpu_slice #(
   parameter int NREGS = 32
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // unit configuration
   input wire logic FPU_PRESENT,
   input wire logic FPU_ENABLE,
   // command
   input wire logic CMD_VALID,
   input wire fpu_pkg::fpu_cmd_t CMD,
   // register load from core
   input wire logic LOAD_VALID,
   input wire logic [fpu_pkg::REG_AW-1:0] LOAD_ADDR,
   input wire logic [fpu_pkg::WORD_W-1:0] LOAD_DATA,
   // register readback
   input wire logic [fpu_pkg::REG_AW-1:0] READ_ADDR,
   output logic [fpu_pkg::WORD_W-1:0] READ_DATA,
   // status
   output fpu_pkg::fpu_status_t STATUS,
   output logic DONE,
   output logic UNDEF
);
   logic [fpu_pkg::WORD_W-1:0] regs [NREGS];
   logic [fpu_pkg::WORD_W-1:0] next_regs [NREGS];
   fpu_pkg::fpu_status_t next_status;
   logic next_done, next_undef;
   logic [fpu_pkg::WORD_W-1:0] next_read;
   logic [fpu_pkg::WORD_W-1:0] a, b, sum;
   logic a_nan, b_nan, a_snan, b_snan, fire;

   function automatic logic is_nan(input logic [31:0] x);
      return x[fpu_pkg::EXP_HI:fpu_pkg::EXP_LO] == fpu_pkg::EXP_MAX && x[fpu_pkg::MAN_W-1:0] != '0;
   endfunction

   // single-precision add, truncating rounding; denormals treated as zero to keep it small
   function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] big, sml;
      logic [7:0] eb, es, d;
      logic [26:0] mb, ms, mr;
      logic [27:0] s;
      logic [31:0] r;
      int lz;
      r = fpu_pkg::WORD_ZERO;
      if (x[30:0] >= y[30:0]) begin
         big = x;
         sml = y;
      end else begin
         big = y;
         sml = x;
      end
      eb = big[fpu_pkg::EXP_HI:fpu_pkg::EXP_LO];
      es = sml[fpu_pkg::EXP_HI:fpu_pkg::EXP_LO];
      if (is_nan(x) || is_nan(y)) begin
         r = fpu_pkg::QNAN_DEFAULT;
      end else if (eb == fpu_pkg::EXP_MAX) begin
         if (es == fpu_pkg::EXP_MAX && x[31] != y[31])
            r = fpu_pkg::QNAN_DEFAULT;
         else
            r = big;
      end else if (eb == 8'h00) begin
         r = {big[31] & sml[31], 31'h00000000};
      end else if (es == 8'h00) begin
         r = big;
      end else begin
         d = eb - es;
         // three guard bits under the hidden one keep small alignment shifts from losing the carry
         // truncation drops them at the end, so results round toward zero, never to nearest
         mb = {1'b1, big[22:0], 3'h0};
         ms = (d > 8'd26) ? 27'h0 : ({1'b1, sml[22:0], 3'h0} >> d);
         if (big[31] == sml[31]) begin
            s = {1'b0, mb} + {1'b0, ms};
         end else begin
            s = {1'b0, mb} - {1'b0, ms};
         end
         if (s == 28'h0) begin
            r = fpu_pkg::WORD_ZERO;
         end else if (s[27]) begin
            if (eb == 8'hfe)
               r = {big[31], fpu_pkg::EXP_MAX, 23'h0};
            else
               r = {big[31], eb + 8'h01, s[26:4]};
         end else begin
            lz = 0;
            for (int i = 26; i >= 0; i--) begin
               if (s[i] == 1'b0 && lz == 26 - i)
                  lz = lz + 1;
            end
            if (lz >= int'(eb)) begin
               r = {big[31], 31'h00000000};
            end else begin
               mr = s[26:0] << lz;
               r = {big[31], eb - 8'(lz), mr[25:3]};
            end
         end
      end
      return r;
   endfunction

   // totally ordered compare of non-NaN values, +0 equals -0
   function automatic logic [3:0] fcmp(input logic [31:0] x, input logic [31:0] y);
      logic xz, yz;
      logic lt;
      xz = x[30:0] == 31'h0;
      yz = y[30:0] == 31'h0;
      if ((xz && yz) || x == y)
         return fpu_pkg::FLAGS_EQ;
      if (x[31] != y[31])
         lt = x[31];
      else if (x[31])
         lt = x[30:0] > y[30:0];
      else
         lt = x[30:0] < y[30:0];
      return lt ? fpu_pkg::FLAGS_LT : fpu_pkg::FLAGS_GT;
   endfunction

   always_comb begin
      a = regs[CMD.src_a];
      b = CMD.cmp_zero ? fpu_pkg::WORD_ZERO : regs[CMD.src_b];
      sum = fadd(a, b);
      a_nan = is_nan(a);
      b_nan = is_nan(b);
      a_snan = a_nan && !a[fpu_pkg::QUIET_BIT];
      b_snan = b_nan && !b[fpu_pkg::QUIET_BIT];
      fire = CMD_VALID && FPU_PRESENT && FPU_ENABLE && CMD.cond_pass;
      next_regs = regs;
      next_status = STATUS;
      next_done = fire;
      next_undef = CMD_VALID && !(FPU_PRESENT && FPU_ENABLE);
      if (LOAD_VALID)
         next_regs[LOAD_ADDR] = LOAD_DATA;
      if (fire) begin
         unique case (CMD.op)
            fpu_pkg::FPU_OP_ABS: begin
               next_regs[CMD.dest] = {1'b0, a[fpu_pkg::SIGN_BIT-1:0]};
            end
            fpu_pkg::FPU_OP_ADD: begin
               next_regs[CMD.dest] = sum;
            end
            fpu_pkg::FPU_OP_CMP: begin
               next_status.flags = (a_nan || b_nan) ? fpu_pkg::FLAGS_UN : fcmp(a, b);
               // sticky: a later compare never clears a raised invalid bit
               if (CMD.cmp_any_nan ? (a_nan || b_nan) : (a_snan || b_snan))
                  next_status.invalid = 1'b1;
            end
            default: begin
            end
         endcase
      end
      next_read = next_regs[READ_ADDR];
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         for (int i = 0; i < NREGS; i++)
            regs[i] <= fpu_pkg::WORD_ZERO;
         STATUS <= '{flags: fpu_pkg::FLAGS_RESET, invalid: 1'b0};
         DONE <= 1'b0;
         UNDEF <= 1'b0;
         READ_DATA <= fpu_pkg::WORD_ZERO;
      end else begin
         regs <= next_regs;
         STATUS <= next_status;
         DONE <= next_done;
         UNDEF <= next_undef;
         READ_DATA <= next_read;
      end
   end

   property p_gate;
      @(posedge MCLK) disable iff (RESET) CMD_VALID && !(FPU_PRESENT && FPU_ENABLE) |=> UNDEF && !DONE;
   endproperty
   a_gate: assert property (p_gate) else $error("op ran while unit disabled");

   property p_cond;
      @(posedge MCLK) disable iff (RESET) CMD_VALID && !CMD.cond_pass |=> !DONE && STATUS == $past(STATUS);
   endproperty
   a_cond: assert property (p_cond) else $error("failed condition still executed");

   property p_abs;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_ABS && !LOAD_VALID
         |=> regs[$past(CMD.dest)] == {1'b0, $past(a[fpu_pkg::SIGN_BIT-1:0])};
   endproperty
   a_abs: assert property (p_abs) else $error("abs result wrong");

   property p_add_flags;
      @(posedge MCLK) disable iff (RESET) fire && CMD.op != fpu_pkg::FPU_OP_CMP |=> STATUS == $past(STATUS);
   endproperty
   a_add_flags: assert property (p_add_flags) else $error("add changed flags");

   property p_cmp_zero;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && CMD.cmp_zero && a[30:0] == 31'h0 |=> STATUS.flags == fpu_pkg::FLAGS_EQ;
   endproperty
   a_cmp_zero: assert property (p_cmp_zero) else $error("zero compare not equal");

   property p_cmp_un;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && (a_nan || b_nan) |=> STATUS.flags == fpu_pkg::FLAGS_UN;
   endproperty
   a_cmp_un: assert property (p_cmp_un) else $error("unordered flags wrong");

   property p_inv_any;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && CMD.cmp_any_nan && (a_nan || b_nan) |=> STATUS.invalid;
   endproperty
   a_inv_any: assert property (p_inv_any) else $error("any-nan compare missed invalid");

   property p_inv_quiet;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && !CMD.cmp_any_nan && !a_snan && !b_snan && !STATUS.invalid
         |=> !STATUS.invalid;
   endproperty
   a_inv_quiet: assert property (p_inv_quiet) else $error("quiet nan raised invalid");

   property p_done;
      @(posedge MCLK) disable iff (RESET)
         fire |=> DONE;
   endproperty
   a_done: assert property (p_done) else $error("executed op gave no done pulse");

   property p_no_done;
      @(posedge MCLK) disable iff (RESET)
         !fire |=> !DONE;
   endproperty
   a_no_done: assert property (p_no_done) else $error("done pulse without an executed op");

   property p_excl;
      @(posedge MCLK) disable iff (RESET)
         !(DONE && UNDEF);
   endproperty
   a_excl: assert property (p_excl) else $error("done and undef together");

   // a load in the same cycle may legally change the destination, so it is left out here
   property p_undef_keep;
      @(posedge MCLK) disable iff (RESET)
         CMD_VALID && !(FPU_PRESENT && FPU_ENABLE) && !LOAD_VALID
         |=> STATUS == $past(STATUS) && regs[$past(CMD.dest)] == $past(regs[CMD.dest]);
   endproperty
   a_undef_keep: assert property (p_undef_keep) else $error("disabled unit changed state");

   property p_cond_keep;
      @(posedge MCLK) disable iff (RESET)
         CMD_VALID && !CMD.cond_pass && !LOAD_VALID |=> regs[$past(CMD.dest)] == $past(regs[CMD.dest]);
   endproperty
   a_cond_keep: assert property (p_cond_keep) else $error("failed condition wrote a register");

   property p_cmp_keep;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && !LOAD_VALID
         |=> regs[$past(CMD.dest)] == $past(regs[CMD.dest]);
   endproperty
   a_cmp_keep: assert property (p_cmp_keep) else $error("compare wrote a register");

   property p_cmp_lt;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && !a_nan && !b_nan && a[fpu_pkg::SIGN_BIT] && !b[fpu_pkg::SIGN_BIT]
         && a[fpu_pkg::SIGN_BIT-1:0] != 31'h0 |=> STATUS.flags == fpu_pkg::FLAGS_LT;
   endproperty
   a_cmp_lt: assert property (p_cmp_lt) else $error("negative against positive not less");

   property p_inv_sig;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_CMP && !CMD.cmp_any_nan && (a_snan || b_snan) |=> STATUS.invalid;
   endproperty
   a_inv_sig: assert property (p_inv_sig) else $error("signalling nan missed invalid");

   // only reset clears invalid, so software can poll it after a run of compares
   property p_inv_keep;
      @(posedge MCLK) disable iff (RESET)
         STATUS.invalid |=> STATUS.invalid;
   endproperty
   a_inv_keep: assert property (p_inv_keep) else $error("invalid bit cleared");

   property p_add_nan;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_ADD && (a_nan || b_nan)
         |=> regs[$past(CMD.dest)] == fpu_pkg::QNAN_DEFAULT;
   endproperty
   a_add_nan: assert property (p_add_nan) else $error("nan add gave no default nan");

   property p_add_zero;
      @(posedge MCLK) disable iff (RESET)
         fire && CMD.op == fpu_pkg::FPU_OP_ADD && b == fpu_pkg::WORD_ZERO
         && a[fpu_pkg::EXP_HI:fpu_pkg::EXP_LO] != 8'h00 && a[fpu_pkg::EXP_HI:fpu_pkg::EXP_LO] != fpu_pkg::EXP_MAX
         |=> regs[$past(CMD.dest)] == $past(a);
   endproperty
   a_add_zero: assert property (p_add_zero) else $error("adding zero changed the value");

   // an executed abs or add wins over a load to the same entry; a compare writes no register, so the load lands
   property p_load;
      @(posedge MCLK) disable iff (RESET)
         LOAD_VALID && !(fire && CMD.op != fpu_pkg::FPU_OP_CMP && CMD.dest == LOAD_ADDR)
         |=> regs[$past(LOAD_ADDR)] == $past(LOAD_DATA);
   endproperty
   a_load: assert property (p_load) else $error("register load lost");

   property p_read;
      @(posedge MCLK) disable iff (RESET)
         1'b1 |=> READ_DATA == regs[$past(READ_ADDR)];
   endproperty
   a_read: assert property (p_read) else $error("readback does not match register");

   c_abs: cover property (@(posedge MCLK) disable iff (RESET) fire && CMD.op == fpu_pkg::FPU_OP_ABS);
   c_add: cover property (@(posedge MCLK) disable iff (RESET) fire && CMD.op == fpu_pkg::FPU_OP_ADD);
   c_inv: cover property (@(posedge MCLK) disable iff (RESET) fire ##1 $rose(STATUS.invalid));
   c_undef: cover property (@(posedge MCLK) disable iff (RESET) CMD_VALID && !(FPU_PRESENT && FPU_ENABLE));
   c_cmp_zero: cover property (@(posedge MCLK) disable iff (RESET) fire && CMD.op == fpu_pkg::FPU_OP_CMP && CMD.cmp_zero);
endmodule // fpu_slice

/* bench/fpu_core_model.sv */
// core-side model: loads slice registers, issues commands, copies status flags
// assumes inputs are driven 1 ns after a rising MCLK edge, one command per edge
`timescale 1ns/100ps
module fpu_core_model (
   // clock
   input wire logic MCLK,
   // toward the slice
   output logic CMD_VALID,
   output fpu_pkg::fpu_cmd_t CMD,
   output logic LOAD_VALID,
   output logic [4:0] LOAD_ADDR,
   output logic [31:0] LOAD_DATA,
   // from the slice
   input wire fpu_pkg::fpu_status_t STATUS,
   output logic [3:0] CORE_FLAGS
);
   initial begin
      CMD_VALID = 1'b0;
      LOAD_VALID = 1'b0;
      CMD = '0;
      LOAD_ADDR = 5'h00;
      LOAD_DATA = 32'h00000000;
      CORE_FLAGS = 4'h0;
   end
   // idle fields carry the inverse of the last value so a stale word never looks current
   task load(logic [4:0] a, logic [31:0] v);
      @(posedge MCLK);
      #1 LOAD_VALID = 1'b1;
      LOAD_ADDR = a;
      LOAD_DATA = v;
      @(posedge MCLK);
      #1 LOAD_VALID = 1'b0;
      LOAD_ADDR = ~a;
      LOAD_DATA = ~v;
   endtask
   task issue(fpu_pkg::fpu_cmd_t c);
      @(posedge MCLK);
      #1 CMD_VALID = 1'b1;
      CMD = c;
      @(posedge MCLK);
      #1 CMD_VALID = 1'b0;
      CMD = fpu_pkg::fpu_cmd_t'(~c);
   endtask
   task move_flags();
      CORE_FLAGS = STATUS.flags;
   endtask
endmodule // fpu_core_model

/* bench/tb_fpu_slice.sv */
// self-checking bench: behavioural model of registers and status against the slice
// assumes fpu_core_model drives the command side 1 ns after each MCLK edge
`timescale 1ns/100ps
module tb_fpu_slice;
   logic MCLK = 1'b0;
   logic RESET = 1'b1;
   logic PRES = 1'b1;
   logic EN = 1'b1;
   logic CMD_VALID, LOAD_VALID, DONE, UNDEF;
   fpu_pkg::fpu_cmd_t CMD;
   logic [4:0] LOAD_ADDR;
   logic [4:0] READ_ADDR = 5'h00;
   logic [31:0] LOAD_DATA, READ_DATA;
   fpu_pkg::fpu_status_t STATUS;
   logic [3:0] CORE_FLAGS;
   logic [31:0] m_reg [32];
   logic [4:0] m_st;
   int failures = 0;
   int total_checks = 0;
   always #50 MCLK = ~MCLK;
   fpu_slice i_fpu_slice (.MCLK(MCLK), .RESET(RESET), .FPU_PRESENT(PRES), .FPU_ENABLE(EN),
      .CMD_VALID(CMD_VALID), .CMD(CMD), .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR),
      .LOAD_DATA(LOAD_DATA), .READ_ADDR(READ_ADDR), .READ_DATA(READ_DATA), .STATUS(STATUS),
      .DONE(DONE), .UNDEF(UNDEF));
   fpu_core_model i_fpu_core_model (.MCLK(MCLK), .CMD_VALID(CMD_VALID), .CMD(CMD),
      .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA), .STATUS(STATUS),
      .CORE_FLAGS(CORE_FLAGS));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset();
      RESET = 1'b1;
      repeat (4) @(posedge MCLK);
      #1 RESET = 1'b0;
      foreach (m_reg[i]) m_reg[i] = 32'h00000000;
      m_st = 5'h00;
   endtask
   function automatic bit nan(logic [31:0] v);
      return v[30:23] == 8'hff && v[22:0] != 23'h0;
   endfunction
   // invalid is sticky, so the old bit is or-ed in
   function automatic logic [4:0] cmp_model(logic [31:0] a, logic [31:0] b, bit anyn, logic [4:0] st);
      bit sig;
      sig = (nan(a) && !a[22]) || (nan(b) && !b[22]);
      if (nan(a) || nan(b)) return {fpu_pkg::FLAGS_UN, st[0] | sig | anyn};
      if (a == b || (a[30:0] == 31'h0 && b[30:0] == 31'h0)) return {fpu_pkg::FLAGS_EQ, st[0]};
      if (a[31] != b[31] ? a[31] : (a[31] ^ (a[30:0] < b[30:0]))) return {fpu_pkg::FLAGS_LT, st[0]};
      return {fpu_pkg::FLAGS_GT, st[0]};
   endfunction
   task automatic ld(logic [4:0] a, logic [31:0] v);
      i_fpu_core_model.load(a, v);
      m_reg[a] = v;
   endtask
   task automatic run(fpu_pkg::fpu_op_t op, logic [4:0] d, logic [4:0] a, logic [4:0] b, bit z, bit anyn,
         bit pass, logic [31:0] sum);
      fpu_pkg::fpu_cmd_t c;
      logic [31:0] bv;
      c = '{op, pass, z, anyn, d, a, b};
      bv = z ? 32'h00000000 : m_reg[b];
      READ_ADDR = d;
      i_fpu_core_model.issue(c);
      check("done", DONE, pass & PRES & EN);
      check("undef", UNDEF, !(PRES & EN));
      if (pass & PRES & EN) begin
         if (op == fpu_pkg::FPU_OP_ABS) m_reg[d] = {1'b0, m_reg[a][30:0]};
         else if (op == fpu_pkg::FPU_OP_ADD) m_reg[d] = sum;
         else m_st = cmp_model(m_reg[a], bv, anyn, m_st);
      end
      check("result", READ_DATA, m_reg[d]);
      check("status", STATUS, m_st);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h191e));
      do_reset();
      for (int i = 1; i < 9; i++) begin
         ld(i[4:0], $urandom);
         run(fpu_pkg::FPU_OP_ABS, 5'(i + 16), i[4:0], 5'h00, 0, 0, 1, 0);
      end
      $display("test abs done");
      ld(5'h01, 32'h3f800000);
      ld(5'h02, 32'h40000000);
      ld(5'h03, 32'hbf800000);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h01, 5'h02, 0, 0, 1, 0);
      run(fpu_pkg::FPU_OP_ADD, 5'h04, 5'h01, 5'h01, 0, 0, 1, 32'h40000000);
      run(fpu_pkg::FPU_OP_ADD, 5'h05, 5'h01, 5'h02, 0, 0, 1, 32'h40400000);
      run(fpu_pkg::FPU_OP_ADD, 5'h06, 5'h02, 5'h03, 0, 0, 1, 32'h3f800000);
      run(fpu_pkg::FPU_OP_ADD, 5'h07, 5'h01, 5'h00, 0, 0, 1, 32'h3f800000);
      $display("test add done");
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h02, 5'h01, 0, 0, 1, 0);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h01, 5'h01, 0, 1, 1, 0);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h03, 5'h01, 1, 0, 1, 0);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h00, 5'h01, 1, 0, 1, 0);
      for (int i = 0; i < 6; i++)
         run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'($urandom % 8 + 1), 5'($urandom % 8 + 1), 0, i[0], 1, 0);
      i_fpu_core_model.move_flags();
      check("core flags", CORE_FLAGS, m_st[4:1]);
      $display("test compare done");
      run(fpu_pkg::FPU_OP_ABS, 5'h11, 5'h03, 5'h00, 0, 0, 0, 0);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h01, 5'h00, 1, 0, 0, 0);
      PRES = 1'b0;
      run(fpu_pkg::FPU_OP_ABS, 5'h12, 5'h03, 5'h00, 0, 0, 1, 0);
      PRES = 1'b1;
      EN = 1'b0;
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h02, 5'h01, 0, 0, 1, 0);
      EN = 1'b1;
      $display("test refuse done");
      do_reset();
      ld(5'h09, 32'h7fc00000);
      ld(5'h0a, 32'h7f800001);
      run(fpu_pkg::FPU_OP_ADD, 5'h0b, 5'h09, 5'h01, 0, 0, 1, 32'h7fc00000);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h09, 5'h01, 0, 0, 1, 0);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h01, 5'h09, 0, 1, 1, 0);
      do_reset();
      ld(5'h0a, 32'h7f800001);
      run(fpu_pkg::FPU_OP_CMP, 5'h00, 5'h0a, 5'h00, 1, 0, 1, 0);
      $display("test nan done");
      complete_run();
   end
endmodule // tb_fpu_slice
